/* src/dmm_data_memory.sv */
// Internal data memory map: working banks, bit area, stack, pointer and special registers.
// Assumes one core issuing one access at a time and an external memory behind the strobes.
`timescale 1ns/10ps
`include "dmm_regs.svh"

// Notes on behaviour
// - Direct high addresses hit special registers.
// - Bottom 32 bytes form four register banks.
// - Bytes 20H-2FH also addressable as bits.
// - Reset loads stack pointer with 07H.
// - Push increments pointer, then writes.
// - Enable bit maps 2K on-chip extended RAM.
// - Pointers above 0007FFH always go external.
// - On-chip hits leave pins and strobes idle.
// - Extended stack enable chooses wrap or 0100H.
// - Extended stack uses upper 1792 bytes.
// - Pointer bytes at 81H and B7H.
// - External moves carry a 24-bit address.
// - Pointer increment carries into page byte.
// - Status word layout, reset 00H.
// - Bank select is a plain binary value.
// - Power control layout, reset 00H.
// - Nonvolatile data space has no direct path.
// - Memory configuration resets to 00H.
module dmm_data_memory #(
  parameter int unsigned EXT_STROBE_CYCLES = `DMM_EXT_STROBE_CYCLES
) (
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic               ce,
  // Core request
  input  wire logic               req_valid,
  input  wire dmm_pkg::dmm_req_t  req,
  output logic                    req_ready,
  // Core answer
  output logic                    rsp_valid,
  output logic [7:0]              rsp_data,
  output logic                    rsp_miss,
  // Arithmetic unit
  input  wire logic [7:0]         accumulator,
  input  wire logic               flags_we,
  input  wire dmm_pkg::dmm_flags_t flags_in,
  // External data memory
  output dmm_pkg::dmm_ext_t       ext_bus,
  input  wire logic [7:0]         ext_rdata,
  // Register contents
  output logic [7:0]              core_status_word,
  output logic [7:0]              power_control,
  output logic [7:0]              memory_config_register,
  output logic [10:0]             stack_pointer,
  output logic [23:0]             data_pointer
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  dmm_pkg::dmm_state_t state;
  dmm_pkg::dmm_state_t next_state;
  logic                sel_extended_data_ram;
  logic                next_sel_extended_data_ram;
  logic                pend_bit;
  logic                next_pend_bit;
  logic                pend_bit_wr;
  logic                next_pend_bit_wr;
  logic [2:0]          bit_idx;
  logic [2:0]          next_bit_idx;
  logic                bit_val;
  logic                next_bit_val;
  logic [7:0]          bit_addr;
  logic [7:0]          next_bit_addr;
  logic [15:0]         ext_cnt;
  logic [15:0]         next_ext_cnt;
  logic [7:0]          sync1;
  logic [7:0]          sync2;
  logic [7:0]          sync3;
  logic                next_rsp_valid;
  logic [7:0]          next_rsp_data;
  logic                next_rsp_miss;
  dmm_pkg::dmm_ext_t   next_ext_bus;
  logic [7:0]          next_psw;
  logic [7:0]          next_pwr;
  logic [7:0]          next_cfg;
  logic [10:0]         next_sp;
  logic [23:0]         next_ptr;

  // Memory ports
  logic                iram_we;
  logic [7:0]          iram_addr;
  logic [7:0]          iram_wdata;
  logic [7:0]          iram_rdata;
  logic                extended_data_ram_we;
  logic [10:0]         extended_data_ram_addr;
  logic [7:0]          extended_data_ram_wdata;
  logic [7:0]          extended_data_ram_rdata;

  // --------------------------------------------------------------------------
  // Decoding
  // --------------------------------------------------------------------------
  function automatic logic is_sfr(input logic [7:0] a);
    is_sfr = (a == `DMM_SFR_STACK_POINTER_LOW)  || (a == `DMM_SFR_DATA_POINTER_LOW)  ||
             (a == `DMM_SFR_DATA_POINTER_HIGH)  || (a == `DMM_SFR_DATA_POINTER_PAGE) ||
             (a == `DMM_SFR_POWER_CONTROL)      || (a == `DMM_SFR_MEMORY_CONFIG)     ||
             (a == `DMM_SFR_STACK_POINTER_HIGH) || (a == `DMM_SFR_CORE_STATUS_WORD);
  endfunction

  wire logic [7:0] a        = req.addr;
  wire logic       ext_en   = memory_config_register[`DMM_CFG_EXTENDED_STACK_EN];
  wire logic       extended_data_ram_en  = memory_config_register[`DMM_CFG_ONCHIP_EXTENDED_DATA_RAM_ENABLE];
  wire logic [1:0] bank     = core_status_word[`DMM_PSW_BANK_HIGH:`DMM_PSW_BANK_LOW];
  wire logic [7:0] reg_addr = {3'b000, bank, a[2:0]};
  wire logic [7:0] bit_byte = a[7] ? {a[7:3], 3'b000} : (`DMM_BIT_AREA_BASE | {4'h0, a[6:3]});
  wire logic       dir_sfr  = a >= `DMM_SFR_SPACE_BASE;
  wire logic       sfr_hit  = is_sfr(a);
  wire logic [10:0] sp_inc  = ext_en ? stack_pointer + 11'h001
                                     : {stack_pointer[10:8], stack_pointer[7:0] + 8'h01};
  wire logic [10:0] sp_dec  = ext_en ? stack_pointer - 11'h001
                                     : {stack_pointer[10:8], stack_pointer[7:0] - 8'h01};
  // stack above FFH in on-chip RAM
  wire logic       push_x   = ext_en && (sp_inc[10:8] != 3'b000);
  wire logic       pop_x    = ext_en && (stack_pointer[10:8] != 3'b000);
  wire logic       x_onchip = extended_data_ram_en && (data_pointer <= `DMM_EXTENDED_DATA_RAM_TOP);
  wire logic [7:0] mem_rd   = sel_extended_data_ram ? extended_data_ram_rdata : iram_rdata;
  wire logic       ext_done = (ext_cnt == 16'h0000) && (!ext_bus.rd_n ? sync2 == sync3 : 1'b1);

  wire logic [7:0] stk_hi_rd = {5'b00000, stack_pointer[10:8]};

  wire logic [7:0] sfr_rdata =
      (a == `DMM_SFR_STACK_POINTER_LOW)  ? stack_pointer[7:0]   :
      (a == `DMM_SFR_STACK_POINTER_HIGH) ? stk_hi_rd            :
      (a == `DMM_SFR_DATA_POINTER_LOW)   ? data_pointer[7:0]    :
      (a == `DMM_SFR_DATA_POINTER_HIGH)  ? data_pointer[15:8]   :
      (a == `DMM_SFR_DATA_POINTER_PAGE)  ? data_pointer[23:16]  :
      (a == `DMM_SFR_POWER_CONTROL)      ? power_control        :
      (a == `DMM_SFR_MEMORY_CONFIG)      ? memory_config_register :
      (a == `DMM_SFR_CORE_STATUS_WORD)   ? core_status_word     : 8'h00;

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    next_state       = state;
    next_sel_extended_data_ram    = sel_extended_data_ram;
    next_pend_bit    = pend_bit;
    next_pend_bit_wr = pend_bit_wr;
    next_bit_idx     = bit_idx;
    next_bit_val     = bit_val;
    next_bit_addr    = bit_addr;
    next_ext_cnt     = ext_cnt;
    next_ext_bus     = ext_bus;
    next_rsp_valid   = 1'b0;
    next_rsp_data    = rsp_data;
    next_rsp_miss    = 1'b0;
    next_psw         = core_status_word;
    next_pwr         = power_control;
    next_cfg         = memory_config_register;
    next_sp          = stack_pointer;
    next_ptr         = data_pointer;
    iram_we          = 1'b0;
    iram_addr        = a;
    iram_wdata       = req.wdata;
    extended_data_ram_we          = 1'b0;
    extended_data_ram_addr        = data_pointer[10:0];
    extended_data_ram_wdata       = req.wdata;
    if (flags_we) begin
      next_psw[`DMM_PSW_CARRY]     = flags_in.carry;
      next_psw[`DMM_PSW_AUX_CARRY] = flags_in.aux_carry;
      next_psw[`DMM_PSW_OVERFLOW]  = flags_in.overflow;
    end
    case (state)
      dmm_pkg::DMM_S_IDLE: begin
        if (req_valid) begin
          next_pend_bit = 1'b0;
          next_sel_extended_data_ram = 1'b0;
          case (req.kind)
            dmm_pkg::DMM_DIR_RD, dmm_pkg::DMM_DIR_WR: begin
              if (dir_sfr) begin
                next_rsp_valid = 1'b1;
                next_rsp_miss  = !sfr_hit;
                next_rsp_data  = sfr_rdata;
                if (req.kind == dmm_pkg::DMM_DIR_WR) begin
                  case (a)
                    `DMM_SFR_STACK_POINTER_LOW:  next_sp[7:0]     = req.wdata;
                    `DMM_SFR_STACK_POINTER_HIGH: if (ext_en) next_sp[10:8] = req.wdata[2:0];
                    `DMM_SFR_DATA_POINTER_LOW:   next_ptr[7:0]    = req.wdata;
                    `DMM_SFR_DATA_POINTER_HIGH:  next_ptr[15:8]   = req.wdata;
                    `DMM_SFR_DATA_POINTER_PAGE:  next_ptr[23:16]  = req.wdata;
                    `DMM_SFR_POWER_CONTROL:      next_pwr         = req.wdata;
                    `DMM_SFR_MEMORY_CONFIG:      next_cfg         = req.wdata;
                    `DMM_SFR_CORE_STATUS_WORD:   next_psw[7:1]    = req.wdata[7:1];
                    default:                     next_rsp_miss    = 1'b1;
                  endcase
                end
              end else if (req.kind == dmm_pkg::DMM_DIR_WR) begin
                iram_we        = 1'b1;
                next_rsp_valid = 1'b1;
              end else begin
                next_state = dmm_pkg::DMM_S_MEM;
              end
            end
            dmm_pkg::DMM_IND_RD, dmm_pkg::DMM_REG_RD: begin
              iram_addr  = (req.kind == dmm_pkg::DMM_REG_RD) ? reg_addr : a;
              next_state = dmm_pkg::DMM_S_MEM;
            end
            dmm_pkg::DMM_IND_WR, dmm_pkg::DMM_REG_WR: begin
              iram_addr      = (req.kind == dmm_pkg::DMM_REG_WR) ? reg_addr : a;
              iram_we        = 1'b1;
              next_rsp_valid = 1'b1;
            end
            dmm_pkg::DMM_BIT_RD, dmm_pkg::DMM_BIT_WR: begin
              if (a[7]) begin
                next_rsp_valid = 1'b1;
                next_rsp_miss  = bit_byte != `DMM_SFR_CORE_STATUS_WORD;
                next_rsp_data  = {7'h00, core_status_word[a[2:0]]};
                if (!next_rsp_miss && req.kind == dmm_pkg::DMM_BIT_WR &&
                    a[2:0] != 3'(`DMM_PSW_PARITY)) begin
                  next_psw[a[2:0]] = req.wdata[0];
                end
              end else begin
                iram_addr        = bit_byte;
                next_bit_addr    = bit_byte;
                next_bit_idx     = a[2:0];
                next_bit_val     = req.wdata[0];
                next_pend_bit    = 1'b1;
                next_pend_bit_wr = req.kind == dmm_pkg::DMM_BIT_WR;
                next_state       = dmm_pkg::DMM_S_MEM;
              end
            end
            dmm_pkg::DMM_PUSH: begin
              next_sp        = sp_inc;
              iram_addr      = sp_inc[7:0];
              extended_data_ram_addr      = sp_inc;
              iram_we        = !push_x;
              extended_data_ram_we        = push_x;
              next_rsp_valid = 1'b1;
            end
            dmm_pkg::DMM_POP: begin
              iram_addr     = stack_pointer[7:0];
              extended_data_ram_addr     = stack_pointer;
              next_sel_extended_data_ram = pop_x;
              next_sp       = sp_dec;
              next_state    = dmm_pkg::DMM_S_MEM;
            end
            dmm_pkg::DMM_XMV_RD, dmm_pkg::DMM_XMV_WR: begin
              if (x_onchip) begin
                extended_data_ram_we        = req.kind == dmm_pkg::DMM_XMV_WR;
                next_sel_extended_data_ram  = 1'b1;
                next_rsp_valid = extended_data_ram_we;
                next_state     = extended_data_ram_we ? dmm_pkg::DMM_S_IDLE : dmm_pkg::DMM_S_MEM;
              end else begin
                next_ext_bus.addr    = data_pointer;
                next_ext_bus.wdata   = req.wdata;
                next_ext_bus.data_oe = req.kind == dmm_pkg::DMM_XMV_WR;
                next_ext_bus.rd_n    = req.kind == dmm_pkg::DMM_XMV_WR;
                next_ext_bus.wr_n    = req.kind != dmm_pkg::DMM_XMV_WR;
                next_ext_cnt         = 16'(EXT_STROBE_CYCLES - 1);
                next_state           = dmm_pkg::DMM_S_EXT;
              end
            end
            dmm_pkg::DMM_PTR_INC: begin
              next_ptr       = data_pointer + 24'h000001;
              next_rsp_valid = 1'b1;
            end
            default: begin
              next_rsp_valid = 1'b1;
              next_rsp_miss  = 1'b1;
            end
          endcase
        end
      end
      dmm_pkg::DMM_S_MEM: begin
        next_rsp_valid = 1'b1;
        next_rsp_data  = pend_bit ? {7'h00, mem_rd[bit_idx]} : mem_rd;
        if (pend_bit && pend_bit_wr) begin
          iram_addr           = bit_addr;
          iram_wdata          = mem_rd;
          iram_wdata[bit_idx] = bit_val;
          iram_we             = 1'b1;
        end
        next_state = dmm_pkg::DMM_S_IDLE;
      end
      dmm_pkg::DMM_S_EXT: begin
        if (ext_cnt != 16'h0000) begin
          next_ext_cnt = ext_cnt - 16'h0001;
        end else if (ext_done) begin
          next_rsp_valid       = 1'b1;
          next_rsp_data        = ext_bus.rd_n ? rsp_data : sync3;
          next_ext_bus.rd_n    = 1'b1;
          next_ext_bus.wr_n    = 1'b1;
          next_ext_bus.data_oe = 1'b0;
          next_state           = dmm_pkg::DMM_S_IDLE;
        end
      end
      default: next_state = dmm_pkg::DMM_S_IDLE;
    endcase
    next_psw[`DMM_PSW_PARITY] = ^accumulator;
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state                  <= dmm_pkg::DMM_S_IDLE;
      req_ready              <= 1'b1;
      sel_extended_data_ram               <= 1'b0;
      pend_bit               <= 1'b0;
      pend_bit_wr            <= 1'b0;
      bit_idx                <= 3'h0;
      bit_val                <= 1'b0;
      bit_addr               <= 8'h00;
      ext_cnt                <= 16'h0000;
      rsp_valid              <= 1'b0;
      rsp_data               <= 8'h00;
      rsp_miss               <= 1'b0;
      ext_bus                <= '{addr: 24'h000000, wdata: 8'h00, data_oe: 1'b0,
                                  rd_n: 1'b1, wr_n: 1'b1};
      core_status_word       <= `DMM_RST_CORE_STATUS_WORD;
      power_control          <= `DMM_RST_POWER_CONTROL;
      memory_config_register <= `DMM_RST_MEMORY_CONFIG;
      stack_pointer          <= `DMM_RST_STACK_POINTER;
      data_pointer           <= `DMM_RST_DATA_POINTER;
    end else if (ce) begin
      state                  <= next_state;
      req_ready              <= next_state == dmm_pkg::DMM_S_IDLE;
      sel_extended_data_ram               <= next_sel_extended_data_ram;
      pend_bit               <= next_pend_bit;
      pend_bit_wr            <= next_pend_bit_wr;
      bit_idx                <= next_bit_idx;
      bit_val                <= next_bit_val;
      bit_addr               <= next_bit_addr;
      ext_cnt                <= next_ext_cnt;
      rsp_valid              <= next_rsp_valid;
      rsp_data               <= next_rsp_data;
      rsp_miss               <= next_rsp_miss;
      ext_bus                <= next_ext_bus;
      core_status_word       <= next_psw;
      power_control          <= next_pwr;
      memory_config_register <= next_cfg;
      stack_pointer          <= next_sp;
      data_pointer           <= next_ptr;
    end
  end

  // Read data from the external pins is resampled three times before use.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
      sync3 <= 8'h00;
    end else if (ce) begin
      sync1 <= ext_rdata;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // --------------------------------------------------------------------------
  // Memories
  // --------------------------------------------------------------------------
  // nonvolatile data space is not decoded here.
  dmm_ram #(.AW(8), .DW(8)) u_iram (
    .sys_clk (sys_clk),
    .ce      (ce),
    .we      (iram_we),
    .addr    (iram_addr),
    .wdata   (iram_wdata),
    .rdata   (iram_rdata)
  );

  dmm_ram #(.AW(11), .DW(8)) u_extended_data_ram (
    .sys_clk (sys_clk),
    .ce      (ce),
    .we      (extended_data_ram_we),
    .addr    (extended_data_ram_addr),
    .wdata   (extended_data_ram_wdata),
    .rdata   (extended_data_ram_rdata)
  );

endmodule

/* src/dmm_regs.svh */
// Register offsets, field positions, reset values and timing counts of the data memory map.
// Assumes inclusion by bare name from files that need these constants.
`ifndef DMM_REGS_SVH
`define DMM_REGS_SVH

// ----------------------------------------------------------------------------
// Special register addresses
// ----------------------------------------------------------------------------
`define DMM_SFR_STACK_POINTER_LOW  8'h81
`define DMM_SFR_DATA_POINTER_LOW   8'h82
`define DMM_SFR_DATA_POINTER_HIGH  8'h83
`define DMM_SFR_DATA_POINTER_PAGE  8'h84
`define DMM_SFR_POWER_CONTROL      8'h87
`define DMM_SFR_MEMORY_CONFIG      8'haf
`define DMM_SFR_STACK_POINTER_HIGH 8'hb7
`define DMM_SFR_CORE_STATUS_WORD   8'hd0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define DMM_RST_STACK_POINTER      11'h007
`define DMM_RST_POWER_CONTROL      8'h00
`define DMM_RST_MEMORY_CONFIG      8'h00
`define DMM_RST_CORE_STATUS_WORD   8'h00
`define DMM_RST_DATA_POINTER       24'h000000

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define DMM_CFG_ONCHIP_EXTENDED_DATA_RAM_ENABLE 0
`define DMM_CFG_EXTENDED_STACK_EN  7
`define DMM_PSW_CARRY              7
`define DMM_PSW_AUX_CARRY          6
`define DMM_PSW_BANK_HIGH          4
`define DMM_PSW_BANK_LOW           3
`define DMM_PSW_OVERFLOW           2
`define DMM_PSW_PARITY             0
`define DMM_STK_HIGH_BITS          3

// ----------------------------------------------------------------------------
// Memory layout
// ----------------------------------------------------------------------------
`define DMM_BIT_AREA_BASE          8'h20
`define DMM_SFR_SPACE_BASE         8'h80
`define DMM_EXTENDED_DATA_RAM_TOP               24'h0007ff
`define DMM_IRAM_DEPTH             256
`define DMM_EXTENDED_DATA_RAM_DEPTH             2048

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define DMM_CLK_PERIOD_NS          8
`define DMM_EXT_STROBE_NS          48
`define DMM_EXT_STROBE_CYCLES ((`DMM_EXT_STROBE_NS + `DMM_CLK_PERIOD_NS - 1) / `DMM_CLK_PERIOD_NS)

`endif

/* src/dmm_pkg.sv */
// Types shared by the data memory map block.
// Assumes nothing beyond a SystemVerilog compiler.
package dmm_pkg;

  // --------------------------------------------------------------------------
  // Core access kinds
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    DMM_DIR_RD   = 4'h0,
    DMM_DIR_WR   = 4'h1,
    DMM_IND_RD   = 4'h2,
    DMM_IND_WR   = 4'h3,
    DMM_REG_RD   = 4'h4,
    DMM_REG_WR   = 4'h5,
    DMM_BIT_RD   = 4'h6,
    DMM_BIT_WR   = 4'h7,
    DMM_PUSH     = 4'h8,
    DMM_POP      = 4'h9,
    DMM_XMV_RD   = 4'ha,
    DMM_XMV_WR   = 4'hb,
    DMM_PTR_INC  = 4'hc
  } dmm_kind_t;

  // --------------------------------------------------------------------------
  // Control states
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    DMM_S_IDLE = 3'b001,
    DMM_S_MEM  = 3'b010,
    DMM_S_EXT  = 3'b100
  } dmm_state_t;

  // --------------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    dmm_kind_t  kind;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dmm_req_t;

  typedef struct packed {
    logic carry;
    logic aux_carry;
    logic overflow;
  } dmm_flags_t;

  typedef struct packed {
    logic [23:0] addr;
    logic [7:0]  wdata;
    logic        data_oe;
    logic        rd_n;
    logic        wr_n;
  } dmm_ext_t;

endpackage

/* src/dmm_ram.sv */
// Single-port synchronous RAM with one cycle of read latency.
// Assumes the caller's clock enable arrives on ce, which gates writes and reads here.
`timescale 1ns/10ps

module dmm_ram #(
  parameter int unsigned AW = 8,
  parameter int unsigned DW = 8
) (
  // Clock
  input  wire logic          sys_clk,
  input  wire logic          ce,
  // Access port
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge sys_clk) begin
    if (ce) begin
      if (we) begin
        mem[addr] <= wdata;
      end
      rdata <= mem[addr];
    end
  end

endmodule

/* dv/dmm_ext_mem_model.sv */
// External data memory model that answers the block's active-low strobes.
// Assumes only the low address byte is decoded, so higher pages alias.
`timescale 1ns/10ps

module dmm_ext_mem_model (
  // Clock
  input  wire logic              sys_clk,
  // Memory bus
  input  wire dmm_pkg::dmm_ext_t ext_bus,
  output logic [7:0]             ext_rdata
);
  logic [7:0] mem [256];
  logic [7:0] junk = 8'h00;

  always_ff @(posedge sys_clk) begin
    junk <= junk + 8'h35;
    if (!ext_bus.wr_n) begin
      mem[ext_bus.addr[7:0]] <= ext_bus.wdata;
    end
  end

  // A released data bus shows a changing pattern, never the last byte.
  assign ext_rdata = ext_bus.rd_n ? junk : mem[ext_bus.addr[7:0]];
endmodule

/* dv/dmm_data_memory_props.sv */
// Checker of the data memory map ports: reset values, stack, pointer, external moves.
// Assumes one clock sys_clk and the active-high rst.
`timescale 1ns/10ps

module dmm_data_memory_props (
  // Clock and reset
  input wire logic              sys_clk,
  input wire logic              rst,
  input wire logic              ce,
  // Core side
  input wire logic              req_valid,
  input wire dmm_pkg::dmm_req_t req,
  input wire logic              req_ready,
  input wire logic              rsp_valid,
  input wire logic [7:0]        rsp_data,
  // Memory side and registers
  input wire dmm_pkg::dmm_ext_t ext_bus,
  input wire logic [7:0]        core_status_word,
  input wire logic [7:0]        power_control,
  input wire logic [7:0]        memory_config_register,
  input wire logic [10:0]       stack_pointer,
  input wire logic [23:0]       data_pointer
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire take = req_valid && req_ready && ce;
  wire push = take && req.kind == dmm_pkg::DMM_PUSH;
  wire xmv  = take && req.kind[3:1] == 3'h5;
  wire xon  = xmv && memory_config_register[0] && data_pointer <= 24'h0007ff;

  sp_reset_a: assert property ($fell(rst) |-> stack_pointer == 11'h007)
    else $error("stack pointer wrong after reset");
  regs_reset_a: assert property ($fell(rst) |->
    {memory_config_register, power_control, core_status_word[7:1]} == 23'h000000)
    else $error("register wrong after reset");
  push_low_a: assert property (push && !memory_config_register[7] |=>
    stack_pointer == {$past(stack_pointer[10:8]), $past(stack_pointer[7:0]) + 8'h01})
    else $error("push did not wrap in low byte");
  ext_stack_a: assert property (push && memory_config_register[7] |=>
    stack_pointer == $past(stack_pointer) + 11'h001) else $error("extended push wrong");
  pop_step_a: assert property (take && req.kind == dmm_pkg::DMM_POP &&
    !memory_config_register[7] |=> !req_ready &&
    stack_pointer == {$past(stack_pointer[10:8]), $past(stack_pointer[7:0]) - 8'h01})
    else $error("pop did not step down in low byte");
  extended_data_ram_quiet_a: assert property (xon |=>
    ext_bus.rd_n && ext_bus.wr_n && !ext_bus.data_oe) else $error("strobe on chip move");
  ext_addr_a: assert property (xmv && !xon |=>
    ext_bus.addr == $past(data_pointer) && !(ext_bus.rd_n && ext_bus.wr_n))
    else $error("external move not on pins");
  ptr_carry_a: assert property (take && req.kind == dmm_pkg::DMM_PTR_INC |=>
    data_pointer == $past(data_pointer) + 24'h000001) else $error("pointer step wrong");
  stk_high_a: assert property (take && req.kind == dmm_pkg::DMM_DIR_RD &&
    req.addr == 8'hb7 |=> rsp_valid && rsp_data == {5'h00, $past(stack_pointer[10:8])})
    else $error("high stack byte read wrong");

  cover property (xon);
  cover property (push && stack_pointer == 11'h0ff);
  cover property (xmv && !xon);
endmodule

bind dmm_data_memory dmm_data_memory_props u_dmm_data_memory_props (
  .sys_clk, .rst, .ce, .req_valid, .req, .req_ready, .rsp_valid, .rsp_data, .ext_bus,
  .core_status_word, .power_control, .memory_config_register, .stack_pointer, .data_pointer);

/* dv/tb_dmm_data_memory.sv */
// Bench for the data memory map: a table of core accesses, then refusal and reset cases.
// Assumes the design, its package, the memory model and the checker are compiled first.
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end

module tb_dmm_data_memory;
  logic              sys_clk = 1'b0;
  logic              rst = 1'b1;
  logic              req_valid = 1'b0;
  dmm_pkg::dmm_req_t req = '0;
  logic              req_ready, rsp_valid, rsp_miss, got_miss;
  logic [7:0]        rsp_data, ext_rdata, core_status_word, power_control, memory_config_register;
  dmm_pkg::dmm_ext_t ext_bus;
  logic [10:0]       stack_pointer;
  logic [23:0]       data_pointer;
  int                miscompares = 0;
  int                cmp_count = 0;
  int                cycles = 0;
  logic [7:0]        accum_value = 8'h00;
  logic              flags_we = 1'b0;
  dmm_pkg::dmm_flags_t flags_in = '0;
  // rows also write and read back power control.
  // Rows are {kind, address, value}: write data for writes, expected data for reads.
  logic [19:0]       rows [56] = '{
    20'h0_81_07, 20'h0_87_00, 20'h0_af_00, 20'h0_d0_00, 20'h1_b7_ff, 20'h0_b7_00, 20'h1_30_a5,
    20'h2_30_a5, 20'h3_90_3c, 20'h2_90_3c, 20'h1_d0_18, 20'h5_05_77, 20'h0_1d_77, 20'h4_05_77,
    20'h0_d0_18, 20'h1_21_00, 20'h7_0b_01, 20'h0_21_08, 20'h1_d0_00, 20'h8_00_5a, 20'h0_81_08,
    20'h0_08_5a, 20'h9_00_5a, 20'h0_81_07, 20'h1_82_ff, 20'h1_83_ff, 20'hc_00_00, 20'h0_84_01,
    20'h0_83_00, 20'hb_00_66, 20'ha_00_66, 20'h1_af_01, 20'h1_84_00, 20'h1_82_10, 20'hb_00_99,
    20'ha_00_99, 20'h1_83_08, 20'h1_82_00, 20'ha_00_66, 20'h1_83_07, 20'h1_82_ff, 20'hb_00_44,
    20'ha_00_44, 20'h1_81_ff, 20'h8_00_11, 20'h0_81_00, 20'h1_af_81, 20'h1_81_ff, 20'h8_00_22,
    20'h0_b7_01, 20'h0_81_00, 20'h9_00_22, 20'h1_b7_ff, 20'h0_b7_07, 20'h1_87_ff, 20'h0_87_ff};

  dmm_data_memory #(.EXT_STROBE_CYCLES(2)) u_dmm_data_memory (
    .sys_clk, .rst, .ce(1'b1), .req_valid, .req, .req_ready, .rsp_valid, .rsp_data, .rsp_miss,
    .accumulator(accum_value), .flags_we, .flags_in, .ext_bus, .ext_rdata,
    .core_status_word, .power_control, .memory_config_register, .stack_pointer, .data_pointer);
  dmm_ext_mem_model u_dmm_ext_mem_model (.sys_clk, .ext_bus, .ext_rdata);

  initial forever #4 sys_clk = ~sys_clk;

  task automatic report_and_stop();
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // One access: present at an edge, wait a bounded time for the answer pulse.
  task automatic access(input logic [3:0] k, input logic [7:0] a, input logic [7:0] w);
    int n;
    req_valid <= 1'b1;
    req <= '{dmm_pkg::dmm_kind_t'(k), a, w};
    @(posedge sys_clk);
    req_valid <= 1'b0;
    #1;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    got_miss = rsp_miss;
    if (n == 20) `CHK("answer", 1'b1, rsp_valid)
    @(posedge sys_clk);
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      report_and_stop();
    end
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    foreach (rows[i]) begin
      access(rows[i][19:16], rows[i][15:8], rows[i][7:0]);
      if (rows[i][19:16] inside {4'h0, 4'h2, 4'h4, 4'h9, 4'ha}) begin
        `CHK("row data", rows[i][7:0], rsp_data)
      end
    end
    access(4'h0, 8'h90, 8'h00);
    `CHK("direct upper read", 1'b1, got_miss)
    accum_value <= 8'h01;
    flags_we    <= 1'b1;
    flags_in    <= 3'b101;
    @(posedge sys_clk);
    flags_we    <= 1'b0;
    access(4'h0, 8'hd0, 8'h00);
    `CHK("status flags", 8'h85, rsp_data)
    rst <= 1'b1;
    @(posedge sys_clk);
    #1;
    `CHK("reset regs", {stack_pointer, memory_config_register, power_control}, 27'h0070000)
    @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    access(4'h0, 8'h81, 8'h00);
    `CHK("stack after reset", 8'h07, rsp_data)
    report_and_stop();
  end
endmodule
